// file: hdl/sfmr_pkg.sv
package sfmr_pkg;
    // ------------------------------------------------------------
    // Command codes and mode byte
    // ------------------------------------------------------------
    localparam logic [7:0] OP_FAST       = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
    localparam logic [7:0] OP_DUAL_AIN   = 8'hBB;
    localparam logic [7:0] OP_QUAD_AIN   = 8'hEB;
    localparam logic [3:0] XIP_NIBBLE    = 4'hA;
    localparam logic [7:0] EMPTY_BYTE    = 8'hFF;

    // ------------------------------------------------------------
    // Phase lengths in serial clocks
    // ------------------------------------------------------------
    localparam int         ADDR_BITS     = 24;
    localparam logic [4:0] CMD_CLKS      = 5'h08;
    localparam logic [4:0] ADDR_CLKS_X1  = 5'h18;
    localparam logic [4:0] ADDR_CLKS_X2  = 5'h0C;
    localparam logic [4:0] ADDR_CLKS_X4  = 5'h06;
    localparam logic [4:0] MODE_CLKS_X2  = 5'h04;
    localparam logic [4:0] MODE_CLKS_X4  = 5'h02;
    localparam logic [4:0] DUMMY_CLKS_X1 = 5'h08;
    localparam logic [4:0] DUMMY_CLKS_X4 = 5'h04;
    localparam logic [3:0] XIP_ABORT_MAX = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         SCK_PERIOD_NS = 160;
    localparam logic [4:0] SCK_HALF_CYC  = 5'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));

    typedef enum logic [2:0] {
        RD_FAST,
        RD_DUAL_OUT,
        RD_QUAD_OUT,
        RD_DUAL_AIN,
        RD_QUAD_AIN
    } sfmr_rd_t;
endpackage : sfmr_pkg

// file: hdl/sfmr_if.sv
`timescale 1ns/1ps
interface sfmr_if;
    logic       sck;
    logic       cs_n;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Resolved pin level; undriven pins float high through a pull-up
    genvar g;
    for (g = 0; g < 4; g++) begin : g_pin
        assign io[g] = dev_io_oe[g]  ? dev_io_o[g]  :
                       host_io_oe[g] ? host_io_o[g] : 1'b1;
    end

    modport host (output sck, output cs_n, output host_io_o, output host_io_oe, input io);
    modport dev  (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);
endinterface : sfmr_if

// file: hdl/sfmr_dev.sv
`timescale 1ns/1ps
// Summary of operation
// - Fast read: command, address, dummy, data
// - Sample inputs on rise, drive on fall
// - Read address advances after each byte
// - Address wraps to zero past top
// - Chip select high ends read, outputs off
// - Reads ignored while device is busy
// - Dual output returns two bits per clock
// - Quad output returns four bits per clock
// - Host releases pins before first data fall
// - Quad commands need quad enable bit
// - Dual address-in: address, mode two-wide
// - Quad address-in: address, mode four-wide
// - Four dummy clocks after quad mode byte
// - Only mode upper nibble is decoded
// - Nibble A keeps continuous dual mode
// - Nibble A keeps continuous quad mode
// - Other nibble leaves continuous mode
// - Short invalid frame exits continuous mode
// - Command byte first, MSB first
// - Code 0B selects quick single read
module sfmr_dev
    import sfmr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    sfmr_if.dev              bus,
    input  wire logic        i_busy,
    input  wire logic        i_quad_enable,
    output logic             o_req_valid,
    output logic [23:0]      o_req_addr,
    input  wire logic        i_req_ready,
    input  wire logic        i_rsp_valid,
    input  wire logic [7:0]  i_rsp_data,
    output logic             o_rsp_ready,
    output logic             o_active,
    output logic             o_xip
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
    } sfmr_st_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_s;
    logic [1:0] cs_s;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic       sck_d;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sck_s <= 2'h0;
            cs_s  <= 2'h3;
            io_m  <= 4'hF;
            io_s  <= 4'hF;
            sck_d <= 1'b0;
        end else if (i_ce) begin
            sck_s <= {sck_s[0], bus.sck};
            cs_s  <= {cs_s[0], bus.cs_n};
            io_m  <= bus.io;
            io_s  <= io_m;
            sck_d <= sck_s[1];
        end
    end

    wire sck_rise = sck_s[1] & ~sck_d;
    wire sck_fall = ~sck_s[1] & sck_d;
    wire cs_high  = cs_s[1];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    sfmr_st_t    state;
    sfmr_rd_t    kind;
    sfmr_rd_t    xip_kind;
    logic        xip_on;
    logic [4:0]  cnt;
    logic [23:0] in_sr;
    logic [23:0] addr;
    logic [3:0]  frame_clks;
    logic [7:0]  out_sr;
    logic [2:0]  out_left;
    logic [3:0]  dq;
    logic [3:0]  dq_oe;
    logic        fetch_on;
    logic        pending;
    logic        drop;

    wire wide_in  = (state == ST_ADDR) || (state == ST_MODE);
    wire in_x4    = wide_in && (kind == RD_QUAD_AIN);
    wire in_x2    = wide_in && (kind == RD_DUAL_AIN);
    wire out_x4   = (kind == RD_QUAD_OUT) || (kind == RD_QUAD_AIN);
    wire out_x2   = (kind == RD_DUAL_OUT) || (kind == RD_DUAL_AIN);
    wire [23:0] in_next = in_x4 ? {in_sr[19:0], io_s}
                        : in_x2 ? {in_sr[21:0], io_s[1:0]}
                        :         {in_sr[22:0], io_s[0]};
    wire [7:0] opcode   = in_next[7:0];
    wire op_fast  = (opcode == OP_FAST);
    wire op_known = op_fast || (opcode == OP_DUAL_OUT) || (opcode == OP_QUAD_OUT)
                  || (opcode == OP_DUAL_AIN) || (opcode == OP_QUAD_AIN);
    wire op_quad  = (opcode == OP_QUAD_OUT) || (opcode == OP_QUAD_AIN);
    wire op_ok    = op_known && !i_busy && (!op_quad || i_quad_enable);
    wire sfmr_rd_t op_kind = (opcode == OP_DUAL_OUT) ? RD_DUAL_OUT
                           : (opcode == OP_QUAD_OUT) ? RD_QUAD_OUT
                           : (opcode == OP_DUAL_AIN) ? RD_DUAL_AIN
                           : (opcode == OP_QUAD_AIN) ? RD_QUAD_AIN : RD_FAST;
    wire [4:0] op_addr_clks = (opcode == OP_QUAD_AIN) ? ADDR_CLKS_X4
                            : (opcode == OP_DUAL_AIN) ? ADDR_CLKS_X2 : ADDR_CLKS_X1;
    wire [4:0] xip_addr_clks = (xip_kind == RD_QUAD_AIN) ? ADDR_CLKS_X4 : ADDR_CLKS_X2;
    wire addr_in_cmd = (kind == RD_DUAL_AIN) || (kind == RD_QUAD_AIN);
    wire last_clk    = (cnt == 5'h01);
    wire short_frame = (frame_clks <= XIP_ABORT_MAX) && (state != ST_DATA);

    // ------------------------------------------------------------
    // Two-entry read buffer
    // ------------------------------------------------------------
    logic [7:0] buf_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] buf_cnt;

    wire buf_full  = (buf_cnt == 2'h2);
    wire buf_empty = (buf_cnt == 2'h0);
    wire byte_load = (state == ST_DATA) && sck_fall && (out_left == 3'h0);
    wire buf_pop   = byte_load && !buf_empty;
    wire buf_push  = i_rsp_valid && o_rsp_ready && !drop;
    wire flush     = cs_high && (state != ST_IDLE);
    wire [7:0] head_byte = buf_empty ? EMPTY_BYTE : buf_mem[rd_ptr];
    wire [1:0] fill      = buf_cnt + {1'b0, pending};

    // Only one fetch is outstanding and it counts against the two entries, so the buffer never overflows
    assign o_req_valid = fetch_on && !pending && (fill < 2'h2);
    assign o_req_addr  = addr;
    assign o_rsp_ready = drop || !buf_full;
    assign o_active    = (state != ST_IDLE);
    assign o_xip       = xip_on;
    assign bus.dev_io_o  = dq;
    assign bus.dev_io_oe = dq_oe;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr  <= 1'b0;
            rd_ptr  <= 1'b0;
            buf_cnt <= 2'h0;
        end else if (i_ce) begin
            if (flush) begin
                wr_ptr  <= 1'b0;
                rd_ptr  <= 1'b0;
                buf_cnt <= 2'h0;
            end else begin
                if (buf_push) begin
                    buf_mem[wr_ptr] <= i_rsp_data;
                    wr_ptr          <= ~wr_ptr;
                end
                if (buf_pop) begin
                    rd_ptr <= ~rd_ptr;
                end
                buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
            end
        end
    end

    // ------------------------------------------------------------
    // Fetch side
    // ------------------------------------------------------------
    wire req_fire = o_req_valid && i_req_ready;
    wire rsp_fire = i_rsp_valid && o_rsp_ready;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pending <= 1'b0;
            drop    <= 1'b0;
        end else if (i_ce) begin
            if (req_fire) begin
                pending <= 1'b1;
            end else if (rsp_fire) begin
                pending <= 1'b0;
            end
            // A fetch still in flight at frame end is discarded on arrival
            if (flush) begin
                drop <= pending && !rsp_fire;
            end else if (rsp_fire) begin
                drop <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state      <= ST_IDLE;
            kind       <= RD_FAST;
            xip_kind   <= RD_DUAL_AIN;
            xip_on     <= 1'b0;
            cnt        <= 5'h00;
            in_sr      <= 24'h00_0000;
            addr       <= 24'h00_0000;
            frame_clks <= 4'h0;
            fetch_on   <= 1'b0;
        end else if (i_ce) begin
            if (req_fire) begin
                addr <= addr + 24'h00_0001;
            end
            if (flush) begin
                state    <= ST_IDLE;
                fetch_on <= 1'b0;
                if (xip_on && short_frame) begin
                    xip_on <= 1'b0;
                end
            end else if (state == ST_IDLE) begin
                if (!cs_high) begin
                    frame_clks <= 4'h0;
                    if (xip_on) begin
                        state <= i_busy ? ST_IGNORE : ST_ADDR;
                        kind  <= xip_kind;
                        cnt   <= xip_addr_clks;
                    end else begin
                        state <= ST_CMD;
                        cnt   <= CMD_CLKS;
                    end
                end
            end else if (sck_rise) begin
                in_sr <= in_next;
                cnt   <= cnt - 5'h01;
                if (frame_clks != 4'hF) begin
                    frame_clks <= frame_clks + 4'h1;
                end
                unique case (state)
                    ST_CMD: begin
                        if (last_clk) begin
                            state <= op_ok ? ST_ADDR : ST_IGNORE;
                            kind  <= op_kind;
                            cnt   <= op_addr_clks;
                        end
                    end
                    ST_ADDR: begin
                        if (last_clk) begin
                            addr     <= in_next;
                            fetch_on <= 1'b1;
                            state    <= addr_in_cmd ? ST_MODE : ST_DUMMY;
                            cnt      <= (kind == RD_QUAD_AIN) ? MODE_CLKS_X4
                                      : (kind == RD_DUAL_AIN) ? MODE_CLKS_X2
                                      : DUMMY_CLKS_X1;
                        end
                    end
                    ST_MODE: begin
                        if (last_clk) begin
                            xip_on   <= (in_next[7:4] == XIP_NIBBLE);
                            xip_kind <= kind;
                            state    <= (kind == RD_QUAD_AIN) ? ST_DUMMY : ST_DATA;
                            cnt      <= DUMMY_CLKS_X4;
                        end
                    end
                    ST_DUMMY: begin
                        if (last_clk) begin
                            state <= ST_DATA;
                        end
                    end
                    ST_DATA, ST_IGNORE, ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Output shifter
    // ------------------------------------------------------------
    wire [7:0] byte_src = (out_left == 3'h0) ? head_byte : out_sr;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            out_sr   <= 8'h00;
            out_left <= 3'h0;
            dq       <= 4'h0;
            dq_oe    <= 4'h0;
        end else if (i_ce) begin
            if ((state != ST_DATA) || cs_high) begin
                out_left <= 3'h0;
                dq_oe    <= 4'h0;
            end else if (sck_fall) begin
                if (out_x4) begin
                    dq       <= byte_src[7:4];
                    dq_oe    <= 4'hF;
                    out_sr   <= {byte_src[3:0], 4'h0};
                    out_left <= out_left - 3'h4;
                end else if (out_x2) begin
                    dq       <= {2'h0, byte_src[7:6]};
                    dq_oe    <= 4'h3;
                    out_sr   <= {byte_src[5:0], 2'h0};
                    out_left <= out_left - 3'h2;
                end else begin
                    dq       <= {2'h0, byte_src[7], 1'b0};
                    dq_oe    <= 4'h2;
                    out_sr   <= {byte_src[6:0], 1'b0};
                    out_left <= out_left - 3'h1;
                end
            end
        end
    end
endmodule : sfmr_dev

// file: hdl/sfmr_host.sv
`timescale 1ns/1ps
module sfmr_host
    import sfmr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    sfmr_if.host             bus,
    input  wire logic        i_start,
    input  wire sfmr_rd_t    i_kind,
    input  wire logic        i_skip_cmd,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_mode,
    input  wire logic [15:0] i_len,
    output logic             o_busy,
    output logic             o_rx_valid,
    output logic [7:0]       o_rx_data
);
    typedef enum logic [2:0] {
        H_IDLE, H_CMD, H_ADDR, H_MODE, H_DUMMY, H_DATA, H_GAP
    } sfmr_hst_t;

    // ------------------------------------------------------------
    // Pin synchroniser and clock divider
    // ------------------------------------------------------------
    logic [3:0]  io_m;
    logic [3:0]  io_s;
    sfmr_hst_t   state;
    sfmr_rd_t    kind;
    logic [4:0]  div;
    logic        sck;
    logic        cs_n;
    logic [4:0]  cnt;
    logic [23:0] tx;
    logic [7:0]  mode;
    logic [15:0] left;
    logic [7:0]  rx_sr;
    logic [2:0]  rx_bits;

    wire tick     = (div == SCK_HALF_CYC - 5'h01);
    wire last_clk = (cnt == 5'h01);
    wire ain_x4   = (kind == RD_QUAD_AIN);
    wire ain_x2   = (kind == RD_DUAL_AIN);
    wire wide_tx  = (state == H_ADDR) || (state == H_MODE);
    wire rx_x4    = (kind == RD_QUAD_OUT) || ain_x4;
    wire rx_x2    = (kind == RD_DUAL_OUT) || ain_x2;
    wire [4:0] addr_clks = ain_x4 ? ADDR_CLKS_X4 : ain_x2 ? ADDR_CLKS_X2 : ADDR_CLKS_X1;
    wire [4:0] ain_clks  = (i_kind == RD_QUAD_AIN) ? ADDR_CLKS_X4 : ADDR_CLKS_X2;
    wire [7:0] rx_next   = rx_x4 ? {rx_sr[3:0], io_s}
                         : rx_x2 ? {rx_sr[5:0], io_s[1:0]}
                         :         {rx_sr[6:0], io_s[1]};
    wire [2:0] rx_step   = rx_x4 ? 3'h4 : rx_x2 ? 3'h2 : 3'h1;

    // Drive from the top of the shifter; address and mode use the wide pins in address-in reads
    assign bus.sck        = sck;
    assign bus.cs_n       = cs_n;
    assign bus.host_io_o  = (wide_tx && ain_x4) ? tx[23:20]
                          : (wide_tx && ain_x2) ? {2'h0, tx[23:22]}
                          : {3'h0, tx[23]};
    assign bus.host_io_oe = (state == H_CMD) ? 4'h1
                          : !wide_tx ? 4'h0
                          : ain_x4 ? 4'hF : ain_x2 ? 4'h3 : 4'h1;
    assign o_busy = (state != H_IDLE);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            io_m <= 4'hF;
            io_s <= 4'hF;
            div  <= 5'h00;
        end else if (i_ce) begin
            io_m <= bus.io;
            io_s <= io_m;
            div  <= (tick || state == H_IDLE) ? 5'h00 : div + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state      <= H_IDLE;
            kind       <= RD_FAST;
            sck        <= 1'b0;
            cs_n       <= 1'b1;
            cnt        <= 5'h00;
            tx         <= 24'h00_0000;
            mode       <= 8'h00;
            left       <= 16'h0000;
            rx_sr      <= 8'h00;
            rx_bits    <= 3'h0;
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
        end else if (i_ce) begin
            o_rx_valid <= 1'b0;
            if (state == H_IDLE) begin
                if (i_start) begin
                    kind <= i_kind;
                    mode <= i_mode;
                    left <= i_len;
                    cs_n <= 1'b0;
                    if (i_skip_cmd) begin
                        state <= H_ADDR;
                        tx    <= i_addr;
                        cnt   <= ain_clks;
                    end else begin
                        state <= H_CMD;
                        cnt   <= CMD_CLKS;
                        unique case (i_kind)
                            RD_FAST:     tx <= {OP_FAST, 16'h0000};
                            RD_DUAL_OUT: tx <= {OP_DUAL_OUT, 16'h0000};
                            RD_QUAD_OUT: tx <= {OP_QUAD_OUT, 16'h0000};
                            RD_DUAL_AIN: tx <= {OP_DUAL_AIN, 16'h0000};
                            RD_QUAD_AIN: tx <= {OP_QUAD_AIN, 16'h0000};
                        endcase
                    end
                end
            end else if (state == H_GAP) begin
                if (tick) begin
                    state <= H_IDLE;
                end
            end else if (tick && !sck) begin
                sck <= 1'b1;
                if (state == H_DATA) begin
                    rx_sr   <= rx_next;
                    rx_bits <= rx_bits + rx_step;
                    if (rx_bits + rx_step == 3'h0) begin
                        o_rx_valid <= 1'b1;
                        o_rx_data  <= rx_next;
                        left       <= left - 16'h0001;
                    end
                end
            end else if (tick) begin
                sck <= 1'b0;
                cnt <= cnt - 5'h01;
                tx  <= (wide_tx && ain_x4) ? {tx[19:0], 4'h0}
                     : (wide_tx && ain_x2) ? {tx[21:0], 2'h0} : {tx[22:0], 1'b0};
                unique case (state)
                    H_CMD: begin
                        if (last_clk) begin
                            state <= H_ADDR;
                            tx    <= i_addr;
                            cnt   <= addr_clks;
                        end
                    end
                    H_ADDR: begin
                        if (last_clk) begin
                            state <= (ain_x4 || ain_x2) ? H_MODE : H_DUMMY;
                            tx    <= {mode, 16'h0000};
                            cnt   <= ain_x4 ? MODE_CLKS_X4
                                   : ain_x2 ? MODE_CLKS_X2 : DUMMY_CLKS_X1;
                        end
                    end
                    H_MODE: begin
                        if (last_clk) begin
                            state <= ain_x4 ? H_DUMMY : H_DATA;
                            cnt   <= DUMMY_CLKS_X4;
                            rx_bits <= 3'h0;
                        end
                    end
                    H_DUMMY: begin
                        if (last_clk) begin
                            state   <= H_DATA;
                            rx_bits <= 3'h0;
                        end
                    end
                    H_DATA: begin
                        if (left == 16'h0000) begin
                            state <= H_GAP;
                            cs_n  <= 1'b1;
                        end
                    end
                    H_IDLE, H_GAP: begin
                    end
                endcase
            end
        end
    end
endmodule : sfmr_host

// file: bench/sfmr_checker.sv
`timescale 1ns/1ps
// ----
// Link checker
// ----
module sfmr_checker (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic [3:0] host_io_o,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_o,
    input wire logic [3:0] dev_io_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_OE_IDLE: assert property (cs_n [*4] |-> dev_io_oe == 4'h0)
        else $error("device drives while deselected");
    AST_CS_END: assert property ($rose(cs_n) |-> ##3 dev_io_oe == 4'h0)
        else $error("device late to release pins");
    AST_NO_FIGHT: assert property ((dev_io_oe & host_io_oe) == 4'h0)
        else $error("pin contention");
    AST_OE_SHAPE: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("bad pin group");
    AST_DRIVE_LOW: assert property ($rose(|dev_io_oe) |-> !cs_n && !sck)
        else $error("drive start off the falling half");
    AST_DEV_LAG: assert property ($fell(sck) && !cs_n |-> $stable(dev_io_o & dev_io_oe) [*3])
        else $error("device output moved too soon");
    AST_HOST_HOLD: assert property (sck && $past(sck) |-> $stable(host_io_o & host_io_oe))
        else $error("host data moved while clock high");
    AST_CS_FIRST: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("clock not low at frame start");
endmodule : sfmr_checker

// file: bench/serial_flash_multi_io_read_test.sv
`timescale 1ns/1ps
module serial_flash_multi_io_read_test;
    import sfmr_pkg::*;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, start = 1'b0, skip = 1'b0, bsy = 1'b0, qe = 1'b1;
    logic        rsp_valid = 1'b0, busy, rx_valid, req_valid, execute_in_place, active, rsp_ready;
    sfmr_rd_t    kind = RD_FAST;
    logic [23:0] addr = 24'h00_0000, req_addr;
    logic [7:0]  mode = 8'h00, rsp_data = 8'h00, rx_data;
    logic [15:0] len = 16'h0001;
    int          miscompares = 0, num_checks = 0;
    always #2.5 i_clk = ~i_clk;
    sfmr_if sfmr_if_inst ();
    sfmr_dev sfmr_dev_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .bus(sfmr_if_inst),
        .i_busy(bsy), .i_quad_enable(qe), .o_req_valid(req_valid), .o_req_addr(req_addr),
        .i_req_ready(1'b1), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
        .o_rsp_ready(rsp_ready), .o_active(active), .o_xip(execute_in_place));
    sfmr_host sfmr_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .bus(sfmr_if_inst),
        .i_start(start), .i_kind(kind), .i_skip_cmd(skip), .i_addr(addr), .i_mode(mode),
        .i_len(len), .o_busy(busy), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
    sfmr_checker sfmr_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .sck(sfmr_if_inst.sck),
        .cs_n(sfmr_if_inst.cs_n), .host_io_o(sfmr_if_inst.host_io_o),
        .host_io_oe(sfmr_if_inst.host_io_oe), .dev_io_o(sfmr_if_inst.dev_io_o),
        .dev_io_oe(sfmr_if_inst.dev_io_oe));
    // ----
    // Array stand-in, answers the cycle after each fetch
    // ----
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h3C;
    endfunction : mem
    always @(posedge i_clk) begin
        rsp_valid <= req_valid;
        rsp_data  <= mem(req_addr);
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    // A refused frame reads the pulled-up pins, so every byte is FF
    task automatic xfer(input sfmr_rd_t k, input logic s, input logic [23:0] a,
                        input logic [7:0] m, input int n, input logic b, input logic q);
        int t;
        logic [23:0] p;
        logic ok;
        @(posedge i_clk);
        kind  <= k;
        skip  <= s;
        addr  <= a;
        mode  <= m;
        len   <= 16'(n);
        bsy   <= b;
        qe    <= q;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        p = a;
        ok = !b && (q || !(k inside {RD_QUAD_OUT, RD_QUAD_AIN}));
        for (int i = 0; i < n; i++) begin
            t = 0;
            do @(negedge i_clk); while (rx_valid !== 1'b1 && ++t < 5000);
            if (t >= 5000) begin
                miscompares++;
                report_and_stop();
            end
            check("rx_data", rx_data, ok ? mem(p) : 8'hFF);
            p = p + 24'h00_0001;
        end
        for (t = 0; busy !== 1'b0 && t < 5000; t++) @(negedge i_clk);
        if (busy !== 1'b0) begin
            miscompares++;
            report_and_stop();
        end
        check("idle", {6'h00, active, rsp_ready}, 8'h01);
    endtask : xfer
    task automatic wrap_all_kinds();
        for (int k = 0; k < 5; k++) xfer(sfmr_rd_t'(k), 1'b0, 24'hFF_FFFE, 8'h00, 3, 1'b0, 1'b1);
    endtask : wrap_all_kinds
    task automatic continuous_mode();
        xfer(RD_QUAD_AIN, 1'b0, 24'h12_3450, 8'hA5, 2, 1'b0, 1'b1);
        check("xip", {7'h00, execute_in_place}, 8'h01);
        xfer(RD_QUAD_AIN, 1'b1, 24'h00_0100, 8'h5A, 2, 1'b0, 1'b1);
        check("xip", {7'h00, execute_in_place}, 8'h00);
        xfer(RD_DUAL_AIN, 1'b0, 24'h40_0007, 8'hA0, 2, 1'b0, 1'b1);
        xfer(RD_DUAL_AIN, 1'b1, 24'h00_0FFF, 8'hAF, 2, 1'b0, 1'b1);
        check("xip", {7'h00, execute_in_place}, 8'h01);
        // Leave continuous mode so that the next frames carry a command byte
        xfer(RD_DUAL_AIN, 1'b1, 24'h7F_FFFF, 8'h00, 1, 1'b0, 1'b1);
        check("xip", {7'h00, execute_in_place}, 8'h00);
    endtask : continuous_mode
    task automatic refused_frames();
        xfer(RD_FAST, 1'b0, 24'h00_0010, 8'h00, 2, 1'b1, 1'b1);
        xfer(RD_QUAD_OUT, 1'b0, 24'h00_0020, 8'h00, 1, 1'b0, 1'b0);
    endtask : refused_frames
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wrap_all_kinds();
        continuous_mode();
        refused_frames();
        report_and_stop();
    end
endmodule : serial_flash_multi_io_read_test
